// >>> bmx_pkg.sv
// shared constants and types of the bit manipulation execute block
package bmx_pkg;

   // register byte offsets on the wishbone slave
   localparam logic [7:0] BMX_OFS_CMD  = 8'h00;
   localparam logic [7:0] BMX_OFS_OPND = 8'h04;
   localparam logic [7:0] BMX_OFS_ADDR = 8'h08;
   localparam logic [7:0] BMX_OFS_DISP = 8'h0C;
   localparam logic [7:0] BMX_OFS_PC   = 8'h10;
   localparam logic [7:0] BMX_OFS_BRW  = 8'h14;
   localparam logic [7:0] BMX_OFS_RES  = 8'h18;
   localparam logic [7:0] BMX_OFS_NPC  = 8'h1C;
   localparam logic [7:0] BMX_OFS_STAT = 8'h20;

   // status register bit positions
   localparam int BMX_STAT_OVF   = 0;
   localparam int BMX_STAT_BUSY  = 1;
   localparam int BMX_STAT_TAKEN = 2;

   // bit literal for n = 0 is the most significant bit
   localparam logic [15:0] BMX_MSB_WEIGHT = 16'h8000;
   localparam logic [15:0] BMX_RST_WORD   = 16'h0000;

   // execution times in ns and the clock period
   localparam int BMX_CLK_NS         = 100;
   localparam int BMX_T_REG_NS       = 800;
   localparam int BMX_T_REG_BR_NS    = 1600;
   localparam int BMX_T_MEM_LONG_NS  = 3400;
   localparam int BMX_T_MEM_SHORT_NS = 2600;
   localparam int BMX_T_BR_LONG_NB_NS  = 3800;
   localparam int BMX_T_BR_LONG_NS     = 4600;
   localparam int BMX_T_BR_SHORT_NB_NS = 3000;
   localparam int BMX_T_BR_SHORT_NS    = 3800;
   localparam int BMX_T_TST_LONG_BR_NS  = 3600;
   localparam int BMX_T_TST_SHORT_BR_NS = 2800;

   // least times: round up to whole cycles
   localparam logic [6:0] BMX_C_REG = 7'((BMX_T_REG_NS + BMX_CLK_NS - 1) / BMX_CLK_NS);
   localparam logic [6:0] BMX_C_REG_BR = 7'((BMX_T_REG_BR_NS + BMX_CLK_NS - 1) / BMX_CLK_NS);
   localparam logic [6:0] BMX_C_MEM_LONG = 7'((BMX_T_MEM_LONG_NS + BMX_CLK_NS - 1) / BMX_CLK_NS);
   localparam logic [6:0] BMX_C_MEM_SHORT = 7'((BMX_T_MEM_SHORT_NS + BMX_CLK_NS - 1) / BMX_CLK_NS);
   localparam logic [6:0] BMX_C_BR_LONG_NB = 7'((BMX_T_BR_LONG_NB_NS + BMX_CLK_NS - 1) / BMX_CLK_NS);
   localparam logic [6:0] BMX_C_BR_LONG = 7'((BMX_T_BR_LONG_NS + BMX_CLK_NS - 1) / BMX_CLK_NS);
   localparam logic [6:0] BMX_C_BR_SHORT_NB = 7'((BMX_T_BR_SHORT_NB_NS + BMX_CLK_NS - 1) / BMX_CLK_NS);
   localparam logic [6:0] BMX_C_BR_SHORT = 7'((BMX_T_BR_SHORT_NS + BMX_CLK_NS - 1) / BMX_CLK_NS);
   localparam logic [6:0] BMX_C_TST_LONG_BR = 7'((BMX_T_TST_LONG_BR_NS + BMX_CLK_NS - 1) / BMX_CLK_NS);
   localparam logic [6:0] BMX_C_TST_SHORT_BR = 7'((BMX_T_TST_SHORT_BR_NS + BMX_CLK_NS - 1) / BMX_CLK_NS);

   typedef enum logic [2:0] {BMX_OP_ADD, BMX_OP_SUB, BMX_OP_CLR, BMX_OP_SET, BMX_OP_INV,
                             BMX_OP_TST} bmx_op_type;
   typedef enum logic [1:0] {BMX_BR_NONE, BMX_BR_NONZERO, BMX_BR_ALWAYS, BMX_BR_BIT_ONE}
      bmx_br_type;
   typedef enum logic [1:0] {BMX_AM_LONG, BMX_AM_DISP, BMX_AM_INDEX, BMX_AM_SPARE}
      bmx_am_type;
   typedef enum logic [2:0] {BMX_ST_IDLE, BMX_ST_EXEC, BMX_ST_MRD, BMX_ST_MWR, BMX_ST_HOLD}
      bmx_state_type;

   // command word layout, bit 15 down to bit 0
   typedef struct packed {
      logic [3:0]  spare;
      bmx_am_type  am;
      bmx_br_type  br;
      logic [3:0]  n;
      logic        mem;
      bmx_op_type  op;
   } bmx_cmd_type;

endpackage

// >>> bmx_execute.sv
// bit manipulation execute unit with wishbone registers and a memory port
//
// Summary of operation
// - add-bit in register adds bit weight, flags overflow above 2^15-1, 0.8 us.
// - subtract-bit in register subtracts bit weight, flags overflow below -2^15.
// - register add/subtract and branch: nonzero loads effective address, else pc plus 2.
// - indexed memory add-bit adds weight to word at index register, flags overflow.
// - short memory branch forms jump to second word when result nonzero.
// - long clear-bit in memory clears only bit n of the word, 3.4 us.
// - long clear-and-branch uses third word if nonzero, else pc plus 3; 3.8/4.6 us.
// - displaced forms address base plus displacement; clear-and-branch takes 3.0/3.8 us.
// - indexed clear-bit clears bit n at index register address, 2.6 us.
// - clear-bit in register and branch when whole register nonzero, 1.6 us.
// - clear-bit in register changes only bit n and raises no flag.
// - set-bit memory forms set bit n only; long 3.4 us, displaced 2.6 us.
// - set-bit in register sets bit n only, 0.8 us.
// - set-bit in register and branch always jumps to effective address, 1.6 us.
// - invert-bit in register complements bit n only.
// - invert-bit and branch jumps when register nonzero, else pc plus 2.
// - long test-bit branches to third word on one, memory untouched; 3.4/3.6 us.
// - short test-bit forms branch to second word on one, else pc plus 2.
// - separate branch words are used directly, no index or indirection.
// - bit field n selects literal 2^(15-n); n zero is the most significant bit.
`timescale 1ns/10ps

module bmx_execute
   import bmx_pkg::*;
(
   input  wire  logic        clk,
   input  wire  logic        reset_n,
   input  wire  logic        wb_cyc,
   input  wire  logic        wb_stb,
   input  wire  logic        wb_we,
   input  wire  logic [7:0]  wb_adr,
   input  wire  logic [3:0]  wb_sel,
   input  wire  logic [31:0] wb_dat_w,
   output logic        [31:0] wb_dat_r,
   output logic              wb_ack,
   output logic              mem_req,
   output logic              mem_we,
   output logic        [15:0] mem_addr,
   output logic        [15:0] mem_wdata,
   input  wire  logic [15:0] mem_rdata,
   input  wire  logic        mem_ack,
   output logic              overflow,
   output logic              busy
);

   typedef struct packed {
      bmx_state_type st;
      logic          ack;
      logic [31:0]   dat;
      bmx_cmd_type   cmd;
      logic [15:0]   opnd;
      logic [15:0]   addr;
      logic [3:0]    disp;
      logic [15:0]   pc;
      logic [15:0]   brw;
      logic [15:0]   res;
      logic [15:0]   npc;
      logic          ovf;
      logic          taken;
      logic          busy;
      logic          mem_req;
      logic          mem_we;
      logic [15:0]   mem_addr;
      logic [15:0]   mem_wdata;
      logic [6:0]    elapsed;
      logic [6:0]    target;
   } bmx_regs_type;

   bmx_regs_type r_ff;
   bmx_regs_type nxt_r;

   logic [15:0] weight;
   logic [15:0] alu_in;
   logic [15:0] alu_res;
   logic        alu_ovf;
   logic        alu_bit;
   logic        alu_taken;
   logic [15:0] alu_npc;
   logic        wb_req;
   logic        ovf_clr;

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic [15:0] bmx_lanes(logic [15:0] old, logic [31:0] d, logic [3:0] s);
      return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction

   // instruction length in words decides the fall-through program counter
   function automatic logic [15:0] bmx_words(bmx_cmd_type c);
      logic [15:0] w;
      w = (c.br == BMX_BR_NONE) ? 16'h0001 : 16'h0002;
      if (c.mem && c.am == BMX_AM_LONG) begin
         w = w + 16'h0001;
      end
      return w;
   endfunction

   function automatic logic [6:0] bmx_cycles(bmx_cmd_type c, logic t);
      logic       longf;
      logic [6:0] cy;
      longf = (c.am == BMX_AM_LONG);
      if (!c.mem) begin
         cy = (c.br == BMX_BR_NONE) ? BMX_C_REG : BMX_C_REG_BR;
      end else if (c.br == BMX_BR_NONE) begin
         cy = longf ? BMX_C_MEM_LONG : BMX_C_MEM_SHORT;
      end else if (c.op == BMX_OP_TST) begin
         cy = longf ? (t ? BMX_C_TST_LONG_BR : BMX_C_MEM_LONG)
                    : (t ? BMX_C_TST_SHORT_BR : BMX_C_MEM_SHORT);
      end else begin
         cy = longf ? (t ? BMX_C_BR_LONG : BMX_C_BR_LONG_NB)
                    : (t ? BMX_C_BR_SHORT : BMX_C_BR_SHORT_NB);
      end
      return cy;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // bit operation on the operand word

   always_comb begin
      logic [15:0] sum;
      logic [15:0] tgt;
      sum     = 16'h0000;
      tgt     = r_ff.cmd.mem ? r_ff.brw : r_ff.addr;
      weight  = BMX_MSB_WEIGHT >> r_ff.cmd.n;
      alu_in  = (r_ff.st == BMX_ST_MRD) ? mem_rdata : r_ff.opnd;
      alu_ovf = 1'b0;
      alu_bit = |(alu_in & weight);
      case (r_ff.cmd.op)
         BMX_OP_ADD: begin
            sum     = alu_in + weight;
            alu_ovf = ~alu_in[15] & sum[15];
            alu_res = sum;
         end
         BMX_OP_SUB: begin
            sum     = alu_in - weight;
            alu_ovf = alu_in[15] & ~sum[15];
            alu_res = sum;
         end
         BMX_OP_CLR: alu_res = alu_in & ~weight;
         BMX_OP_SET: alu_res = alu_in | weight;
         BMX_OP_INV: alu_res = alu_in ^ weight;
         default:    alu_res = alu_in;
      endcase
      case (r_ff.cmd.br)
         BMX_BR_NONZERO: alu_taken = (alu_res != 16'h0000);
         BMX_BR_ALWAYS:  alu_taken = 1'b1;
         BMX_BR_BIT_ONE: alu_taken = alu_bit;
         default:        alu_taken = 1'b0;
      endcase
      alu_npc = alu_taken ? tgt : r_ff.pc + bmx_words(r_ff.cmd);
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers, bus slave and sequencing

   assign wb_req  = wb_cyc && wb_stb && !r_ff.ack;
   assign ovf_clr = wb_req && wb_we && wb_adr == BMX_OFS_STAT && wb_sel[0]
                    && wb_dat_w[BMX_STAT_OVF];

   always_comb begin
      nxt_r     = r_ff;
      nxt_r.ack = 1'b0;
      if (ovf_clr) begin
         nxt_r.ovf = 1'b0;
      end
      if (wb_req) begin
         nxt_r.ack = 1'b1;
         nxt_r.dat = 32'h0000_0000;
         if (wb_we) begin
            // everything but status is frozen while an operation runs
            if (!r_ff.busy) begin
               case (wb_adr)
                  BMX_OFS_CMD: begin
                     nxt_r.cmd     = bmx_cmd_type'(bmx_lanes(r_ff.cmd, wb_dat_w, wb_sel));
                     nxt_r.st      = BMX_ST_EXEC;
                     nxt_r.busy    = 1'b1;
                     nxt_r.elapsed = 7'h01;
                  end
                  BMX_OFS_OPND: nxt_r.opnd = bmx_lanes(r_ff.opnd, wb_dat_w, wb_sel);
                  BMX_OFS_ADDR: nxt_r.addr = bmx_lanes(r_ff.addr, wb_dat_w, wb_sel);
                  BMX_OFS_DISP: begin
                     if (wb_sel[0]) begin
                        nxt_r.disp = wb_dat_w[3:0];
                     end
                  end
                  BMX_OFS_PC:   nxt_r.pc = bmx_lanes(r_ff.pc, wb_dat_w, wb_sel);
                  BMX_OFS_BRW:  nxt_r.brw = bmx_lanes(r_ff.brw, wb_dat_w, wb_sel);
                  default: ;
               endcase
            end
         end else begin
            case (wb_adr)
               BMX_OFS_CMD:  nxt_r.dat = {16'h0000, r_ff.cmd};
               BMX_OFS_OPND: nxt_r.dat = {16'h0000, r_ff.opnd};
               BMX_OFS_ADDR: nxt_r.dat = {16'h0000, r_ff.addr};
               BMX_OFS_DISP: nxt_r.dat = {28'h0000000, r_ff.disp};
               BMX_OFS_PC:   nxt_r.dat = {16'h0000, r_ff.pc};
               BMX_OFS_BRW:  nxt_r.dat = {16'h0000, r_ff.brw};
               BMX_OFS_RES:  nxt_r.dat = {16'h0000, r_ff.res};
               BMX_OFS_NPC:  nxt_r.dat = {16'h0000, r_ff.npc};
               BMX_OFS_STAT: nxt_r.dat = {29'h0, r_ff.taken, r_ff.busy, r_ff.ovf};
               default:      nxt_r.dat = 32'h0000_0000;
            endcase
         end
      end

      if (r_ff.busy) begin
         nxt_r.elapsed = r_ff.elapsed + 7'h01;
      end

      case (r_ff.st)
         BMX_ST_IDLE: ;
         BMX_ST_EXEC: begin
            if (r_ff.cmd.mem) begin
               nxt_r.mem_req = 1'b1;
               nxt_r.mem_we  = 1'b0;
               nxt_r.st      = BMX_ST_MRD;
               case (r_ff.cmd.am)
                  BMX_AM_DISP:  nxt_r.mem_addr = r_ff.opnd + {12'h000, r_ff.disp};
                  BMX_AM_INDEX: nxt_r.mem_addr = r_ff.opnd;
                  default:      nxt_r.mem_addr = r_ff.addr;
               endcase
            end else begin
               nxt_r.res    = alu_res;
               nxt_r.taken  = alu_taken;
               nxt_r.npc    = alu_npc;
               nxt_r.target = bmx_cycles(r_ff.cmd, alu_taken);
               nxt_r.st     = BMX_ST_HOLD;
               if (alu_ovf) begin
                  nxt_r.ovf = 1'b1;
               end
            end
         end
         BMX_ST_MRD: begin
            if (mem_ack) begin
               nxt_r.mem_req = 1'b0;
               nxt_r.res     = alu_res;
               nxt_r.taken   = alu_taken;
               nxt_r.npc     = alu_npc;
               nxt_r.target  = bmx_cycles(r_ff.cmd, alu_taken);
               if (alu_ovf) begin
                  nxt_r.ovf = 1'b1;
               end
               // a test only reads, the word is never rewritten
               if (r_ff.cmd.op == BMX_OP_TST) begin
                  nxt_r.st = BMX_ST_HOLD;
               end else begin
                  nxt_r.mem_req   = 1'b1;
                  nxt_r.mem_we    = 1'b1;
                  nxt_r.mem_wdata = alu_res;
                  nxt_r.st        = BMX_ST_MWR;
               end
            end
         end
         BMX_ST_MWR: begin
            if (mem_ack) begin
               nxt_r.mem_req = 1'b0;
               nxt_r.mem_we  = 1'b0;
               nxt_r.st      = BMX_ST_HOLD;
            end
         end
         BMX_ST_HOLD: begin
            // a slow memory stretches the time; it is never shortened
            if (r_ff.elapsed >= r_ff.target) begin
               nxt_r.busy = 1'b0;
               nxt_r.st   = BMX_ST_IDLE;
            end
         end
         default: nxt_r.st = BMX_ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         r_ff <= '0;
      end else begin
         r_ff <= nxt_r;
      end
   end

   assign wb_dat_r  = r_ff.dat;
   assign wb_ack    = r_ff.ack;
   assign mem_req   = r_ff.mem_req;
   assign mem_we    = r_ff.mem_we;
   assign mem_addr  = r_ff.mem_addr;
   assign mem_wdata = r_ff.mem_wdata;
   assign overflow  = r_ff.ovf;
   assign busy      = r_ff.busy;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   logic exec_reg;
   logic rd_done;
   logic finish;
   assign exec_reg = (r_ff.st == BMX_ST_EXEC) && !r_ff.cmd.mem;
   assign rd_done  = (r_ff.st == BMX_ST_MRD) && mem_ack;
   assign finish   = (r_ff.st == BMX_ST_HOLD) && (r_ff.elapsed >= r_ff.target);

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   a_add_ovf_set: assert property (exec_reg && r_ff.cmd.op == BMX_OP_ADD && !r_ff.opnd[15]
      && r_ff.opnd[15:0] + weight >= 16'h8000 |=> r_ff.ovf && r_ff.res == $past(r_ff.opnd) + $past(weight))
      else $error("add overflow not flagged");
   a_sub_ovf_set: assert property (exec_reg && r_ff.cmd.op == BMX_OP_SUB && r_ff.opnd[15]
      && r_ff.opnd - weight < 16'h8000 |=> r_ff.ovf)
      else $error("subtract overflow not flagged");
   a_reg_nz_jump: assert property (exec_reg && r_ff.cmd.br == BMX_BR_NONZERO
      |=> r_ff.npc == (r_ff.res != 16'h0000 ? r_ff.addr : r_ff.pc + 16'h0002))
      else $error("register branch target wrong");
   a_clr_mem_word: assert property (rd_done && r_ff.cmd.op == BMX_OP_CLR
      |=> r_ff.mem_we && r_ff.mem_wdata == ($past(mem_rdata) & ~weight))
      else $error("cleared memory word wrong");
   a_set_mem_word: assert property (rd_done && r_ff.cmd.op == BMX_OP_SET
      |=> r_ff.mem_we && r_ff.mem_wdata == ($past(mem_rdata) | weight))
      else $error("set memory word wrong");
   a_test_no_write: assert property (rd_done && r_ff.cmd.op == BMX_OP_TST
      |=> !r_ff.mem_req && r_ff.st == BMX_ST_HOLD)
      else $error("test form wrote memory");
   a_mem_br_word: assert property (rd_done && r_ff.cmd.br != BMX_BR_NONE
      |=> r_ff.npc == (r_ff.taken ? r_ff.brw
                       : r_ff.pc + (r_ff.cmd.am == BMX_AM_LONG ? 16'h0003 : 16'h0002)))
      else $error("memory branch target wrong");
   a_disp_addr: assert property (r_ff.st == BMX_ST_EXEC && r_ff.cmd.mem
      && r_ff.cmd.am == BMX_AM_DISP |=> r_ff.mem_addr == $past(r_ff.opnd) + $past(r_ff.disp))
      else $error("displaced address wrong");
   a_reg_time: assert property (finish && !r_ff.cmd.mem
      |-> r_ff.elapsed == (r_ff.cmd.br == BMX_BR_NONE ? 7'h08 : 7'h10))
      else $error("register form time wrong");
   a_long_clr_time: assert property (finish && r_ff.cmd.mem && r_ff.cmd.op == BMX_OP_CLR
      && r_ff.cmd.am == BMX_AM_LONG && r_ff.cmd.br == BMX_BR_NONZERO
      |-> r_ff.elapsed >= (r_ff.taken ? 7'h2E : 7'h26))
      else $error("long clear branch time wrong");
   a_ovf_sticky: assert property (r_ff.ovf && !ovf_clr |=> r_ff.ovf)
      else $error("overflow cleared by the unit");
   a_ack_pulse: assert property (wb_ack |=> !wb_ack)
      else $error("bus acknowledge held too long");
   a_reg_clr_only: assert property (exec_reg && r_ff.cmd.op == BMX_OP_CLR
      |=> r_ff.res == ($past(r_ff.opnd) & ~weight) && ($past(r_ff.ovf) || !r_ff.ovf))
      else $error("register clear touched other bits or flags");
   a_reg_set_bit: assert property (exec_reg && r_ff.cmd.op == BMX_OP_SET
      |=> r_ff.res == ($past(r_ff.opnd) | weight))
      else $error("register set bit wrong");
   a_reg_inv_bit: assert property (exec_reg && r_ff.cmd.op == BMX_OP_INV
      |=> r_ff.res == ($past(r_ff.opnd) ^ weight))
      else $error("register invert bit wrong");
   a_always_jump: assert property (exec_reg && r_ff.cmd.br == BMX_BR_ALWAYS
      |=> r_ff.taken && r_ff.npc == r_ff.addr)
      else $error("unconditional jump missed");
   a_inv_nz_jump: assert property (exec_reg && r_ff.cmd.op == BMX_OP_INV
      && r_ff.cmd.br == BMX_BR_NONZERO |=> r_ff.taken == (r_ff.res != 16'h0000))
      else $error("invert branch decision wrong");
   a_index_addr: assert property (r_ff.st == BMX_ST_EXEC && r_ff.cmd.mem
      && r_ff.cmd.am == BMX_AM_INDEX |=> r_ff.mem_addr == $past(r_ff.opnd))
      else $error("indexed address wrong");
   a_long_addr: assert property (r_ff.st == BMX_ST_EXEC && r_ff.cmd.mem
      && r_ff.cmd.am == BMX_AM_LONG |=> r_ff.mem_addr == $past(r_ff.addr))
      else $error("long address wrong");
   a_bit_weight: assert property (weight == (16'h0001 << (4'hF - r_ff.cmd.n)))
      else $error("bit literal weight wrong");
   a_test_time: assert property (finish && r_ff.cmd.mem && r_ff.cmd.op == BMX_OP_TST
      && r_ff.cmd.br == BMX_BR_BIT_ONE |-> r_ff.elapsed >= (r_ff.cmd.am == BMX_AM_LONG
      ? (r_ff.taken ? 7'h24 : 7'h22) : (r_ff.taken ? 7'h1C : 7'h1A)))
      else $error("test branch time wrong");
   a_mem_add_ovf: assert property (rd_done && r_ff.cmd.op == BMX_OP_ADD && !mem_rdata[15]
      && mem_rdata + weight >= 16'h8000 |=> r_ff.ovf)
      else $error("memory add overflow not flagged");

endmodule

// >>> bmx_mem_model.sv
// behavioural main memory facing the bit execute unit
`timescale 1ns/10ps
module bmx_mem_model (
   input  wire  logic        clk,
   input  wire  logic        reset_n,
   input  wire  logic        mem_req,
   input  wire  logic        mem_we,
   input  wire  logic [15:0] mem_addr,
   input  wire  logic [15:0] mem_wdata,
   input  wire  logic [3:0]  wait_cycles,
   output logic        [15:0] mem_rdata,
   output logic              mem_ack
);
   logic [15:0] mem [0:255];
   logic [3:0]  cnt_ff;

   ////////////////////////////////////////////////////////////////////////////////
   // read data is only good in the ack cycle; it toggles elsewhere so a late sample shows
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mem_ack   <= 1'b0;
         cnt_ff    <= 4'h0;
         mem_rdata <= 16'h5A5A;
      end else if (mem_req && !mem_ack && cnt_ff == wait_cycles) begin
         mem_ack   <= 1'b1;
         cnt_ff    <= 4'h0;
         mem_rdata <= mem[mem_addr[7:0]];
         if (mem_we) begin
            mem[mem_addr[7:0]] <= mem_wdata;
         end
      end else begin
         mem_ack   <= 1'b0;
         mem_rdata <= ~mem_rdata;
         if (mem_req && !mem_ack) begin
            cnt_ff <= cnt_ff + 4'h1;
         end
      end
   end
endmodule

// >>> tb_top.sv
// self-checking testbench of the bit execute unit
`timescale 1ns/10ps
module tb_top
   import bmx_pkg::*;
;
   typedef struct packed {
      logic [15:0] cmd, opnd, mval, eres, enpc;
      logic        ovf, tkn;
      logic [7:0]  cyc;
   } bmx_tb_row_type;

   logic           clk, reset_n, wb_cyc, wb_stb, wb_we, wb_ack;
   logic           mem_req, mem_we, mem_ack, overflow, busy;
   logic [7:0]     wb_adr;
   logic [3:0]     wb_sel, wait_cycles;
   logic [31:0]    wb_dat_w, wb_dat_r;
   logic [15:0]    mem_addr, mem_wdata, mem_rdata, q;
   int             err_count, cmp_count, busy_cyc;
   bmx_tb_row_type rows [0:21];

   bmx_execute i_bmx_execute (.clk(clk), .reset_n(reset_n), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
      .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r),
      .wb_ack(wb_ack), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .overflow(overflow),
      .busy(busy));
   bmx_mem_model i_bmx_mem_model (.clk(clk), .reset_n(reset_n), .mem_req(mem_req),
      .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .wait_cycles(wait_cycles),
      .mem_rdata(mem_rdata), .mem_ack(mem_ack));

   always #50 clk = ~clk;

   always @(negedge clk) begin
      if (busy === 1'b1) begin
         busy_cyc++;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one classic cycle; the leading edge keeps cyc low a cycle between requests
   task automatic wb_rw(input logic we, input logic [7:0] adr, input logic [15:0] d,
                        output logic [15:0] rd);
      @(posedge clk);
      wb_cyc   <= 1'b1;
      wb_stb   <= 1'b1;
      wb_we    <= we;
      wb_adr   <= adr;
      wb_sel   <= 4'h3;
      wb_dat_w <= {16'h0000, d};
      // no timeout here; without an ack only the watchdog ends this wait
      do begin
         @(posedge clk);
      end while (wb_ack !== 1'b1);
      rd = wb_dat_r[15:0];
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we  <= 1'b0;
   endtask

   // clr: clear overflow first; poke: write operand while busy; exact: busy length must equal cyc, else only at least cyc
   task automatic run_op(input bmx_tb_row_type r, input logic clr, input logic poke,
                         input logic exact);
      logic [15:0] rd;
      logic [7:0]  ea;
      logic        eovf;
      int          n;
      eovf = r.ovf | !clr;
      ea = (r.cmd[11:10] == 2'h0) ? 8'h40 : (r.cmd[11:10] == 2'h1) ? r.opnd[7:0] + 8'h03
         : r.opnd[7:0];
      if (r.cmd[3]) begin
         i_bmx_mem_model.mem[ea] = r.mval;
      end
      if (clr) begin
         wb_rw(1'b1, BMX_OFS_STAT, 16'h0001, rd);
      end
      wb_rw(1'b1, BMX_OFS_OPND, r.opnd, rd);
      wb_rw(1'b1, BMX_OFS_ADDR, 16'h0040, rd);
      wb_rw(1'b1, BMX_OFS_DISP, 16'h0003, rd);
      wb_rw(1'b1, BMX_OFS_PC, 16'h0100, rd);
      wb_rw(1'b1, BMX_OFS_BRW, 16'h0200, rd);
      busy_cyc = 0;
      wb_rw(1'b1, BMX_OFS_CMD, r.cmd, rd);
      if (poke) begin
         wb_rw(1'b1, BMX_OFS_OPND, 16'h1234, rd);
      end
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (busy === 1'b1 && n < 200);
      if (exact) begin
         check("busy_len", r.cyc, busy_cyc);
      end else begin
         check("busy_min", 1, busy_cyc >= r.cyc);
      end
      wb_rw(1'b0, BMX_OFS_RES, 16'h0000, rd);
      check("result", r.eres, rd);
      if (r.cmd[3]) begin
         check("mem_word", r.eres, i_bmx_mem_model.mem[ea]);
      end
      wb_rw(1'b0, BMX_OFS_NPC, 16'h0000, rd);
      check("next_pc", r.enpc, rd);
      wb_rw(1'b0, BMX_OFS_STAT, 16'h0000, rd);
      check("status", {r.tkn, 1'b0, eovf}, rd[2:0]);
      check("overflow", eovf, overflow);
      if (poke) begin
         wb_rw(1'b0, BMX_OFS_OPND, 16'h0000, rd);
         check("opnd_kept", r.opnd, rd);
      end
   endtask

   task automatic final_report;
      $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      final_report();
   end

   initial begin
      clk = 1'b0; reset_n = 1'b0; wb_cyc = 1'b0; wb_stb = 1'b0; wb_we = 1'b0;
      wb_adr = 8'h00; wb_sel = 4'h0; wb_dat_w = 32'h0; wait_cycles = 4'h0;
      err_count = 0; cmp_count = 0; busy_cyc = 0;
      rows = '{
         '{16'h0010,16'h4000,16'h0000,16'h8000,16'h0101,1'b1,1'b0,8'h08},
         '{16'h0011,16'hC000,16'h0000,16'h8000,16'h0101,1'b0,1'b0,8'h08},
         '{16'h01F1,16'h8000,16'h0000,16'h7FFF,16'h0040,1'b1,1'b1,8'h10},
         '{16'h01F0,16'hFFFF,16'h0000,16'h0000,16'h0102,1'b0,1'b0,8'h10},
         '{16'h01F2,16'h0001,16'h0000,16'h0000,16'h0102,1'b0,1'b0,8'h10},
         '{16'h01F2,16'h0003,16'h0000,16'h0002,16'h0040,1'b0,1'b1,8'h10},
         '{16'h0002,16'hFFFF,16'h0000,16'h7FFF,16'h0101,1'b0,1'b0,8'h08},
         '{16'h0283,16'h0000,16'h0000,16'h0080,16'h0040,1'b0,1'b1,8'h10},
         '{16'h0144,16'h0800,16'h0000,16'h0000,16'h0102,1'b0,1'b0,8'h10},
         '{16'h0144,16'h0000,16'h0000,16'h0800,16'h0040,1'b0,1'b1,8'h10},
         '{16'h0044,16'h0000,16'h0000,16'h0800,16'h0101,1'b0,1'b0,8'h08},
         '{16'h0003,16'h0001,16'h0000,16'h8001,16'h0101,1'b0,1'b0,8'h08},
         '{16'h000A,16'h0000,16'hFFFF,16'h7FFF,16'h0102,1'b0,1'b0,8'h22},
         '{16'h01FA,16'h0000,16'h0001,16'h0000,16'h0103,1'b0,1'b0,8'h26},
         '{16'h01FA,16'h0000,16'h0003,16'h0002,16'h0200,1'b0,1'b1,8'h2E},
         '{16'h050A,16'h0050,16'h8001,16'h0001,16'h0200,1'b0,1'b1,8'h26},
         '{16'h08FA,16'h0060,16'h0003,16'h0002,16'h0101,1'b0,1'b0,8'h1A},
         '{16'h0918,16'h0060,16'h4000,16'h8000,16'h0200,1'b1,1'b1,8'h26},
         '{16'h047B,16'h0050,16'h0000,16'h0100,16'h0101,1'b0,1'b0,8'h1A},
         '{16'h030D,16'h0000,16'h8000,16'h8000,16'h0200,1'b0,1'b1,8'h24},
         '{16'h030D,16'h0000,16'h7FFF,16'h7FFF,16'h0103,1'b0,1'b0,8'h22},
         '{16'h07FD,16'h0050,16'h0001,16'h0001,16'h0200,1'b0,1'b1,8'h1C}};
      repeat (2) @(posedge clk);
      #1;
      check("reset_outs", 4'h0, {overflow, busy, mem_req, wb_ack});
      @(posedge clk);
      reset_n <= 1'b1;
      wb_rw(1'b0, BMX_OFS_STAT, 16'h0000, q);
      check("status_rst", 16'h0000, q);
      wb_rw(1'b0, 8'h24, 16'h0000, q);
      check("unmapped", 16'h0000, q);
      foreach (rows[i]) begin
         run_op(rows[i], 1'b1, 1'b0, 1'b1);
      end
      // overflow from an add must survive a following clear-bit operation
      run_op(rows[0], 1'b1, 1'b0, 1'b1);
      run_op(rows[6], 1'b0, 1'b0, 1'b1);
      wb_rw(1'b1, BMX_OFS_STAT, 16'h0001, q);
      check("ovf_cleared", 1'b0, overflow);
      wait_cycles <= 4'h3;
      run_op(rows[12], 1'b1, 1'b1, 1'b0);
      // a reset in the middle of a slow memory operation must leave everything idle
      wb_rw(1'b1, BMX_OFS_CMD, rows[12].cmd, q);
      repeat (4) @(posedge clk);
      reset_n <= 1'b0;
      @(posedge clk);
      check("reset_mid", 4'h0, {overflow, busy, mem_req, wb_ack});
      reset_n <= 1'b1;
      wb_rw(1'b0, BMX_OFS_RES, 16'h0000, q);
      check("res_rst", 16'h0000, q);
      run_op(rows[0], 1'b1, 1'b0, 1'b1);
      final_report();
   end
endmodule
